// ### verilog/data_modulator.sv
// Notes on behaviour
// (R1) output is carrier ANDed with modulator
// (R2) modulator high uses high carrier, low low
// (R3) disable keeps all source selections
// (R4) disabled module drives output pin low
// (R5) 4-bit modulator source select, 14-15 reserved
// (R6) 3-bit high carrier source select
// (R7) low carrier select uses same encoding
// (R8) synced switch waits for pulse to end
// (R9) separate sync enables per carrier
// (R10) per-carrier polarity inversion
// (R11) software bit can be modulator source
// (R12) output invert bit flips pin
// (R13) keeps running while sources keep running
// (R14) reset disables module, defaults everything
// (R15) power-down clears module to reset state
// (R16) sync waits for carrier falling edge
// (R17) status shows output; invert idles high
// (R18) five control registers at fixed addresses
// (R19) asynchronous sources tolerated
// (R20) sync only delays, never adds pulses
`timescale 1ns/1ps
`default_nettype none

module data_modulator (
    input  wire logic                                    clk,
    input  wire logic                                    reset,
    input  wire logic                                    modulePowerDown,
    input  wire logic                                    enable,
    input  wire logic                                    outputInvert,
    input  wire logic                                    softwareModulationBit,
    input  wire logic                                    highCarrierInvert,
    input  wire logic                                    highCarrierSyncEnable,
    input  wire logic                                    lowCarrierInvert,
    input  wire logic                                    lowCarrierSyncEnable,
    input  wire logic [3:0]                              modulatorSourceSelect,
    input  wire logic [2:0]                              highCarrierSelect,
    input  wire logic [2:0]                              lowCarrierSelect,
    input  wire logic [data_modulator_pkg::MOD_IN_W-1:0] modulatorInputs,
    input  wire logic [data_modulator_pkg::CAR_IN_W-1:0] carrierInputs,
    output var  logic                                    modulatedOutputPin,
    output var  logic                                    outputStatus
);

    data_modulator_pkg::config_t        cfg_q, cfg_d;
    data_modulator_pkg::carrier_state_t state_q, state_d;
    logic                               highPrev_q, highPrev_d;
    logic                               lowPrev_q, lowPrev_d;
    logic                               pin_q, pin_d;
    logic                               status_q, status_d;
    logic                               highC;
    logic                               lowC;
    logic                               highFall;
    logic                               lowFall;
    logic                               useHigh;
    logic                               mixed;

    source_if ifc ();

    // ========================================================
    // mixing: high carrier ANDed with the modulator,
    // low carrier ANDed with its complement
    function automatic logic mix(
        input logic selHigh,
        input logic high,
        input logic low
    );
        mix = (high & selHigh) | (low & ~selHigh);
    endfunction : mix

    // ========================================================
    // configuration
    // the settings are held here so that power-down can
    // return them to defaults; a disable leaves them alone
    always_comb
    begin
        cfg_d = data_modulator_pkg::CFG_RESET;
        if (!modulePowerDown) // see R15
        begin
            cfg_d.enable       = enable;
            cfg_d.outputInvert = outputInvert;
            cfg_d.softwareBit  = softwareModulationBit;
            cfg_d.highInvert   = highCarrierInvert;
            cfg_d.highSync     = highCarrierSyncEnable;
            cfg_d.lowInvert    = lowCarrierInvert;
            cfg_d.lowSync      = lowCarrierSyncEnable;
            cfg_d.modSel       = modulatorSourceSelect; // see R3
            cfg_d.highSel      = highCarrierSelect;
            cfg_d.lowSel       = lowCarrierSelect;
        end
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            cfg_q <= data_modulator_pkg::CFG_RESET; // see R14
        else
            cfg_q <= cfg_d;
    end

    // ========================================================
    // source selection and synchronisation
    // sources cross in through two flops: output lags by
    // three cycles and carriers above clk/2 are not followed
    assign ifc.modSel  = cfg_q.modSel;
    assign ifc.highSel = cfg_q.highSel;
    assign ifc.lowSel  = cfg_q.lowSel;
    assign ifc.swBit   = cfg_q.softwareBit;

    source_select u_source_select (
        .clk             (clk),
        .reset           (reset),
        .clear           (modulePowerDown),
        .modulatorInputs (modulatorInputs), // see R19
        .carrierInputs   (carrierInputs),
        .sel             (ifc.selector)
    );

    assign highC    = ifc.highCar ^ cfg_q.highInvert; // see R10
    assign lowC     = ifc.lowCar ^ cfg_q.lowInvert;   // see R10
    assign highFall = highPrev_q & ~highC;
    assign lowFall  = lowPrev_q & ~lowC;

    // ========================================================
    // carrier switching
    // a waiting state keeps the old carrier until its pulse
    // falls; the modulator only gets delayed, never changed
    always_comb
    begin
        state_d    = state_q;
        highPrev_d = highC;
        lowPrev_d  = lowC;
        if (!cfg_q.enable)
        begin
            state_d = ifc.modSig ? data_modulator_pkg::HIGH_ACTIVE
                                 : data_modulator_pkg::LOW_ACTIVE;
        end
        else
        begin
            unique case (state_q)
                data_modulator_pkg::LOW_ACTIVE:
                begin
                    if (ifc.modSig) // see R2
                    begin
                        if (cfg_q.lowSync && !lowFall) // see R9
                            state_d = data_modulator_pkg::WAIT_LOW_FALL; // see R8
                        else
                            state_d = data_modulator_pkg::HIGH_ACTIVE;
                    end
                end
                data_modulator_pkg::HIGH_ACTIVE:
                begin
                    if (!ifc.modSig) // see R2
                    begin
                        if (cfg_q.highSync && !highFall) // see R9
                            state_d = data_modulator_pkg::WAIT_HIGH_FALL; // see R8
                        else
                            state_d = data_modulator_pkg::LOW_ACTIVE;
                    end
                end
                data_modulator_pkg::WAIT_HIGH_FALL:
                begin
                    if (ifc.modSig)
                        state_d = data_modulator_pkg::HIGH_ACTIVE; // see R20
                    else if (highFall)
                        state_d = data_modulator_pkg::LOW_ACTIVE; // see R16
                end
                data_modulator_pkg::WAIT_LOW_FALL:
                begin
                    if (!ifc.modSig)
                        state_d = data_modulator_pkg::LOW_ACTIVE; // see R20
                    else if (lowFall)
                        state_d = data_modulator_pkg::HIGH_ACTIVE; // see R16
                end
            endcase
        end
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            state_q    <= data_modulator_pkg::LOW_ACTIVE;
            highPrev_q <= 1'b0;
            lowPrev_q  <= 1'b0;
        end
        else
        begin
            state_q    <= state_d;
            highPrev_q <= highPrev_d;
            lowPrev_q  <= lowPrev_d;
        end
    end

    // ========================================================
    // output stage
    // no dependence on any sleep state: runs while clk runs (see R13)
    always_comb
    begin
        useHigh = (state_d == data_modulator_pkg::HIGH_ACTIVE)
               || (state_d == data_modulator_pkg::WAIT_HIGH_FALL);
        mixed   = mix(useHigh, highC, lowC); // see R1
        if (cfg_q.enable)
            pin_d = mixed ^ cfg_q.outputInvert; // see R12
        else
            pin_d = data_modulator_pkg::RST_PIN; // see R4
        status_d = pin_d; // see R17
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            pin_q    <= data_modulator_pkg::RST_PIN;
            status_q <= data_modulator_pkg::RST_PIN;
        end
        else
        begin
            pin_q    <= pin_d;
            status_q <= status_d;
        end
    end

    assign modulatedOutputPin = pin_q;
    assign outputStatus       = status_q;

    // ========================================================
    // checks
    property p_disabledLow;
        @(posedge clk) disable iff (reset)
        !cfg_q.enable |=> !modulatedOutputPin;
    endproperty
    a_disabledLow: assert property (p_disabledLow) // see R4
        else $error("pin not low while disabled");

    property p_powerDown;
        @(posedge clk) disable iff (reset)
        modulePowerDown |=> (cfg_q == data_modulator_pkg::CFG_RESET) ##1 !modulatedOutputPin;
    endproperty
    a_powerDown: assert property (p_powerDown) // see R15
        else $error("power-down did not clear module");

    property p_highWait;
        @(posedge clk) disable iff (reset)
        cfg_q.enable && state_q == data_modulator_pkg::HIGH_ACTIVE
        && !ifc.modSig && cfg_q.highSync && highC
        |=> state_q == data_modulator_pkg::WAIT_HIGH_FALL;
    endproperty
    a_highWait: assert property (p_highWait) // see R8
        else $error("high carrier cut without sync");

    property p_noSyncSwitch;
        @(posedge clk) disable iff (reset)
        cfg_q.enable && state_q == data_modulator_pkg::HIGH_ACTIVE
        && !ifc.modSig && !cfg_q.highSync
        |=> state_q == data_modulator_pkg::LOW_ACTIVE;
    endproperty
    a_noSyncSwitch: assert property (p_noSyncSwitch) // see R9
        else $error("unsynced switch delayed");

    property p_fallSwitch;
        @(posedge clk) disable iff (reset)
        cfg_q.enable && state_q == data_modulator_pkg::WAIT_HIGH_FALL
        && !ifc.modSig && highPrev_q && !highC
        |=> state_q == data_modulator_pkg::LOW_ACTIVE;
    endproperty
    a_fallSwitch: assert property (p_fallSwitch) // see R16
        else $error("no switch on falling edge");

    property p_abortWait;
        @(posedge clk) disable iff (reset)
        cfg_q.enable && state_q == data_modulator_pkg::WAIT_HIGH_FALL && ifc.modSig
        |=> state_q == data_modulator_pkg::HIGH_ACTIVE;
    endproperty
    a_abortWait: assert property (p_abortWait) // see R20
        else $error("wait not abandoned");

    property p_lowPath;
        @(posedge clk) disable iff (reset)
        cfg_q.enable && !cfg_q.outputInvert && !ifc.modSig
        && state_q == data_modulator_pkg::LOW_ACTIVE
        |=> modulatedOutputPin == $past(lowC);
    endproperty
    a_lowPath: assert property (p_lowPath) // see R2
        else $error("low carrier not on pin");

    property p_idleHigh;
        @(posedge clk) disable iff (reset)
        cfg_q.enable && cfg_q.outputInvert && !ifc.modSig && !lowC
        && state_q == data_modulator_pkg::LOW_ACTIVE
        |=> modulatedOutputPin;
    endproperty
    a_idleHigh: assert property (p_idleHigh) // see R12
        else $error("inverted idle not high");

    property p_status;
        @(posedge clk) disable iff (reset)
        outputStatus == modulatedOutputPin;
    endproperty
    a_status: assert property (p_status) // see R17
        else $error("status differs from pin");

    property p_coverHighWait;
        @(posedge clk) disable iff (reset)
        state_q == data_modulator_pkg::WAIT_HIGH_FALL ##1
        state_q == data_modulator_pkg::LOW_ACTIVE;
    endproperty
    c_coverHighWait: cover property (p_coverHighWait);

    property p_coverLowWait;
        @(posedge clk) disable iff (reset)
        state_q == data_modulator_pkg::WAIT_LOW_FALL ##1
        state_q == data_modulator_pkg::HIGH_ACTIVE;
    endproperty
    c_coverLowWait: cover property (p_coverLowWait);

    property p_coverPulse;
        @(posedge clk) disable iff (reset)
        cfg_q.enable && modulatedOutputPin ##1 !modulatedOutputPin;
    endproperty
    c_coverPulse: cover property (p_coverPulse);

endmodule : data_modulator

`default_nettype wire

// ### common/data_modulator_pkg.sv
package data_modulator_pkg;

    // ========================================================
    // widths of the source buses
    localparam int MOD_IN_W = 14;
    localparam int CAR_IN_W = 8;

    // ========================================================
    // source codes
    localparam logic [3:0] MOD_SRC_SOFTWARE = 4'h1;
    localparam logic [3:0] MOD_SRC_LAST     = 4'hD;
    localparam logic [2:0] CAR_SEL_SYSCLK   = 3'h1;

    // ========================================================
    // configuration and its values after reset
    typedef struct packed {
        logic       enable;
        logic       outputInvert;
        logic       softwareBit;
        logic       highInvert;
        logic       highSync;
        logic       lowInvert;
        logic       lowSync;
        logic [3:0] modSel;
        logic [2:0] lowSel;
        logic [2:0] highSel;
    } config_t;

    localparam config_t CFG_RESET = '{
        enable:       1'b0,
        outputInvert: 1'b0,
        softwareBit:  1'b0,
        highInvert:   1'b0,
        highSync:     1'b0,
        lowInvert:    1'b0,
        lowSync:      1'b0,
        modSel:       4'h0,
        lowSel:       3'h0,
        highSel:      3'h0
    };

    localparam logic RST_PIN = 1'b0;

    // ========================================================
    // register window, kept for the bus that sits outside
    localparam logic [15:0] REG_FIRST = 16'h0F51; // see R18
    localparam int          REG_COUNT = 5;        // see R18

    // ========================================================
    // which carrier is being mixed
    typedef enum logic [1:0] {
        LOW_ACTIVE     = 2'b00,
        HIGH_ACTIVE    = 2'b01,
        WAIT_HIGH_FALL = 2'b10,
        WAIT_LOW_FALL  = 2'b11
    } carrier_state_t;

endpackage : data_modulator_pkg

// ### common/source_if.sv
`timescale 1ns/1ps
`default_nettype none

interface source_if;
    logic [3:0] modSel;
    logic [2:0] highSel;
    logic [2:0] lowSel;
    logic       swBit;
    logic       modSig;
    logic       highCar;
    logic       lowCar;

    modport selector (
        input  modSel, highSel, lowSel, swBit,
        output modSig, highCar, lowCar
    );

    modport mixer (
        output modSel, highSel, lowSel, swBit,
        input  modSig, highCar, lowCar
    );
endinterface : source_if

`default_nettype wire

// ### verilog/source_select.sv
`timescale 1ns/1ps
`default_nettype none

module source_select (
    input  wire logic                                 clk,
    input  wire logic                                 reset,
    input  wire logic                                 clear,
    input  wire logic [data_modulator_pkg::MOD_IN_W-1:0] modulatorInputs,
    input  wire logic [data_modulator_pkg::CAR_IN_W-1:0] carrierInputs,
    source_if.selector                                sel
);

    logic [data_modulator_pkg::MOD_IN_W-1:0] modMeta_q, modMeta_d;
    logic [data_modulator_pkg::MOD_IN_W-1:0] modSync_q, modSync_d;
    logic [data_modulator_pkg::CAR_IN_W-1:0] carMeta_q, carMeta_d;
    logic [data_modulator_pkg::CAR_IN_W-1:0] carSync_q, carSync_d;
    logic                                    sysTog_q,  sysTog_d;
    logic [data_modulator_pkg::MOD_IN_W-1:0] modPick;
    logic [data_modulator_pkg::CAR_IN_W-1:0] carPick;

    // ========================================================
    // two-stage synchronisers, cleared while powered down
    always_comb
    begin
        modMeta_d = clear ? '0 : modulatorInputs;
        modSync_d = clear ? '0 : modMeta_q;
        carMeta_d = clear ? '0 : carrierInputs;
        carSync_d = clear ? '0 : carMeta_q;
        // system clock carrier seen at half rate: a flop cannot sample its own clock
        sysTog_d  = clear ? 1'b0 : ~sysTog_q;
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            modMeta_q <= '0;
            modSync_q <= '0;
            carMeta_q <= '0;
            carSync_q <= '0;
            sysTog_q  <= 1'b0;
        end
        else
        begin
            modMeta_q <= modMeta_d;
            modSync_q <= modSync_d;
            carMeta_q <= carMeta_d;
            carSync_q <= carSync_d;
            sysTog_q  <= sysTog_d;
        end
    end

    // ========================================================
    // source muxes
    always_comb
    begin
        modPick    = modSync_q;
        modPick[1] = sel.swBit; // see R11
        carPick    = carSync_q;
        carPick[data_modulator_pkg::CAR_SEL_SYSCLK] = sysTog_q;
        // reserved modulator codes give a constant low
        if (sel.modSel > data_modulator_pkg::MOD_SRC_LAST) // see R5
            sel.modSig = 1'b0;
        else
            sel.modSig = modPick[sel.modSel];
        sel.highCar = carPick[sel.highSel]; // see R6
        sel.lowCar  = carPick[sel.lowSel];  // see R7
    end

    // ========================================================
    // checks
    property p_swBit;
        @(posedge clk) disable iff (reset)
        sel.modSel == data_modulator_pkg::MOD_SRC_SOFTWARE |-> sel.modSig == sel.swBit;
    endproperty
    a_swBit: assert property (p_swBit) // see R11
        else $error("software bit not used as modulator");

endmodule : source_select

`default_nettype wire

// ### verification/source_model.sv
`timescale 1ns/1ps
`default_nettype none

module source_model #(
    parameter int HALF = 4
) (
    input  wire logic        clk,
    input  wire logic        runCarrier,
    input  wire logic [7:0]  carLevels,
    input  wire logic [13:0] modLevels,
    output var  logic [7:0]  carrierInputs,
    output var  logic [13:0] modulatorInputs
);
    // ========================================================
    // free-running carrier on bit 0
    int   cnt   = 0;
    logic wave  = 1'b0;

    // moves off the clock edge: sources are unrelated to clk
    always @(posedge clk)
    begin
        #37;
        if (!runCarrier || cnt == HALF - 1)
        begin
            cnt  = 0;
            wave = runCarrier ? ~wave : 1'b0;
        end
        else
            cnt = cnt + 1;
    end

    assign carrierInputs   = runCarrier ? {carLevels[7:1], wave} : carLevels;
    assign modulatorInputs = modLevels;
endmodule : source_model

`default_nettype wire

// ### verification/data_modulator_bench.sv
`timescale 1ns/1ps
`default_nettype none

module data_modulator_bench;
    localparam int HALF = 4;

    logic        clk = 1'b0;
    logic        reset = 1'b1;
    logic        modulePowerDown = 1'b0;
    logic        enable = 1'b0;
    logic        outputInvert = 1'b0;
    logic        swBit = 1'b0;
    logic        highInv = 1'b0;
    logic        highSync = 1'b0;
    logic        lowInv = 1'b0;
    logic        lowSync = 1'b0;
    logic [3:0]  modSel = 4'h0;
    logic [2:0]  highSel = 3'h0;
    logic [2:0]  lowSel = 3'h0;
    logic        runCarrier = 1'b0;
    logic [7:0]  carLevels = 8'h00;
    logic [13:0] modLevels = 14'h0000;
    logic [13:0] modulatorInputs;
    logic [7:0]  carrierInputs;
    logic        pin;
    logic        status;
    int          miscompares = 0;
    int          numChecks = 0;
    int          runLen = 0;
    int          runs = 0;
    int          shortRuns = 0;

    always #50 clk = ~clk;

    source_model #(.HALF(HALF)) source_model_i (
        .clk             (clk),
        .runCarrier      (runCarrier),
        .carLevels       (carLevels),
        .modLevels       (modLevels),
        .carrierInputs   (carrierInputs),
        .modulatorInputs (modulatorInputs)
    );

    data_modulator data_modulator_i (
        .clk                   (clk),
        .reset                 (reset),
        .modulePowerDown       (modulePowerDown),
        .enable                (enable),
        .outputInvert          (outputInvert),
        .softwareModulationBit (swBit),
        .highCarrierInvert     (highInv),
        .highCarrierSyncEnable (highSync),
        .lowCarrierInvert      (lowInv),
        .lowCarrierSyncEnable  (lowSync),
        .modulatorSourceSelect (modSel),
        .highCarrierSelect     (highSel),
        .lowCarrierSelect      (lowSel),
        .modulatorInputs       (modulatorInputs),
        .carrierInputs         (carrierInputs),
        .modulatedOutputPin    (pin),
        .outputStatus          (status)
    );

    // ========================================================
    // high-run lengths on the pin, for the sync scenarios
    always @(posedge clk)
    begin
        if (pin === 1'b1)
            runLen <= runLen + 1;
        else if (runLen != 0)
        begin
            runs      <= runs + 1;
            shortRuns <= shortRuns + ((runLen != HALF) ? 1 : 0);
            runLen    <= 0;
        end
    end

    // ========================================================
    // helpers
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #10;
    endtask : tick

    task automatic check(input logic seen, input logic exp);
        numChecks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("BAD at %0t: saw %b expected %b", $time, seen, exp);
        end
    endtask : check

    task automatic conclude;
        $display("checks %0d mismatches %0d", numChecks, miscompares);
        if (miscompares == 0 && numChecks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : conclude

    // three edges from a source to the pin, one spare
    task automatic settle;
        tick(4);
        check(status, pin);
    endtask : settle

    // ========================================================
    // scenarios
    task automatic testReset;
        tick(8);
        check(pin, 1'b0);
        reset = 1'b0;
        tick(1);
        check(pin, 1'b0);
        $display("reset done");
    endtask : testReset

    task automatic testMixing;
        logic [5:0] v;
        logic       exp;
        enable  = 1'b1;
        modSel  = data_modulator_pkg::MOD_SRC_SOFTWARE;
        highSel = 3'h0;
        lowSel  = 3'h2;
        for (int i = 0; i < 64; i++)
        begin
            v = i[5:0];
            {swBit, carLevels[0], carLevels[2], highInv, lowInv, outputInvert} = v;
            exp = outputInvert ^ (swBit ? carLevels[0] ^ highInv : carLevels[2] ^ lowInv);
            settle();
            check(pin, exp);
        end
        $display("mixing done");
    endtask : testMixing

    task automatic testModSources;
        logic [13:0] hot;
        {swBit, highInv, lowInv, outputInvert} = 4'h0;
        carLevels = 8'h01;
        for (int c = 0; c < 16; c++)
        begin
            if (c == 1)
                continue;
            modSel    = c[3:0];
            hot       = 14'h0001 << c;
            modLevels = hot;
            settle();
            check(pin, c < 14);
            modLevels = ~hot;
            settle();
            check(pin, 1'b0);
        end
        modLevels = 14'h0000;
        $display("modulator sources done");
    endtask : testModSources

    task automatic testCarrierSel;
        logic [7:0] hot;
        logic       prev;
        modSel = data_modulator_pkg::MOD_SRC_SOFTWARE;
        for (int s = 0; s < 2; s++)
        begin
            swBit = (s == 0);
            for (int c = 0; c < 8; c++)
            begin
                if (c == 1)
                    continue;
                highSel   = (s == 0) ? c[2:0] : 3'h3;
                lowSel    = (s == 1) ? c[2:0] : 3'h3;
                hot       = 8'h01 << c;
                carLevels = hot;
                settle();
                check(pin, 1'b1);
                carLevels = ~hot;
                settle();
                check(pin, 1'b0);
            end
        end
        // system clock carrier shows as a toggle on every edge
        highSel = data_modulator_pkg::CAR_SEL_SYSCLK;
        swBit   = 1'b1;
        settle();
        prev    = pin;
        tick(1);
        check(pin, ~prev);
        $display("carrier selects done");
    endtask : testCarrierSel

    task automatic testEnableAndPower;
        carLevels = 8'h01;
        highSel   = 3'h0;
        swBit     = 1'b1;
        enable    = 1'b0;
        settle();
        check(pin, 1'b0);
        outputInvert = 1'b1;
        settle();
        check(pin, 1'b0);
        outputInvert = 1'b0;
        enable       = 1'b1;
        settle();
        check(pin, 1'b1);
        modulePowerDown = 1'b1;
        settle();
        check(pin, 1'b0);
        modulePowerDown = 1'b0;
        settle();
        check(pin, 1'b1);
        reset = 1'b1;
        tick(2);
        check(pin, 1'b0);
        reset = 1'b0;
        settle();
        check(pin, 1'b1);
        $display("enable and power done");
    endtask : testEnableAndPower

    // toggling carrier on code 0, the other carrier held low
    task automatic testSync(input logic useLow);
        int runsBefore;
        int n;
        highSel    = useLow ? 3'h2 : 3'h0;
        lowSel     = useLow ? 3'h0 : 3'h2;
        highSync   = !useLow;
        lowSync    = useLow;
        carLevels  = 8'h00;
        swBit      = useLow;
        runCarrier = 1'b1;
        tick(12);
        runs      = 0;
        shortRuns = 0;
        swBit     = !useLow;
        tick(6 * HALF);
        n = 0;
        while (carrierInputs[0] !== 1'b0 && n < 20)
        begin
            tick(1);
            n++;
        end
        while (carrierInputs[0] !== 1'b1 && n < 20)
        begin
            tick(1);
            n++;
        end
        if (n >= 20)
            miscompares++;
        tick(1);
        // flip and restore the modulator while the pulse is still high
        swBit      = useLow;
        tick(1);
        swBit      = !useLow;
        tick(1);
        runsBefore = runs;
        swBit      = useLow;
        tick(8 * HALF);
        check(shortRuns == 0, 1'b1);
        check(runs <= runsBefore + 1, 1'b1);
        check(pin, 1'b0);
        runCarrier = 1'b0;
        // let the source model see the stop so the next run starts in phase
        tick(1);
        $display("sync done, low side %b", useLow);
    endtask : testSync

    initial
    begin
        testReset();
        testMixing();
        testModSources();
        testCarrierSel();
        testEnableAndPower();
        testSync(1'b0);
        testSync(1'b1);
        conclude();
    end
endmodule : data_modulator_bench

`default_nettype wire
